/* tb/lss_host_model.sv */
/*
 Behavioural mode 0 bus master driving the frame slave's serial pins.
 Assumes the slave's select, clock, input and output pins meet its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module lss_host_model (
	output logic sclk_out,
	output logic select_n_out,
	output logic sdi_out,
	input wire logic sdo_in,
	input wire logic sdo_oe_n_in
);
	int bad_status = 0;
	logic sdo_line;

	assign sdo_line = sdo_oe_n_in ? ~sdo_in : sdo_in;

	initial begin
		sclk_out = 1'b0;
		select_n_out = 1'b1;
		sdi_out = 1'b0;
	end

	// ------------------------------------------------------------
	// One frame, clock high across select fall if bad_mode, else still outside it
	// ------------------------------------------------------------
	task automatic frame(input logic [15:0] tx, input int pulses, input bit bad_mode,
		output logic [15:0] rx);
		rx = 16'h0000;
		#17.3;
		sclk_out = bad_mode;
		#31;
		select_n_out = 1'b0;
		sdi_out = tx[15];
		#100;
		sclk_out = 1'b0;
		#31;
		for (int i = 0; i < pulses; i++) begin
			#31.25;
			sclk_out = 1'b1;
			rx = {rx[14:0], sdo_line};
			#62.5;
			sclk_out = 1'b0;
			sdi_out = (i < 15) ? tx[14 - i] : ~sdi_out;
			#31.25;
		end
		#62.5;
		select_n_out = 1'b1;
		sdi_out = ~sdi_out;
		if (pulses == 16 && !bad_mode && (rx[15:8] == 8'hff || rx[15:8] == 8'h00)) begin
			bad_status++;
		end
		#150;
	endtask

	// ------------------------------------------------------------
	// Select low with idle clock
	// ------------------------------------------------------------
	task automatic peek(output logic b, output logic oe_n);
		#17.3;
		select_n_out = 1'b0;
		#100;
		b = sdo_line;
		oe_n = sdo_oe_n_in;
		select_n_out = 1'b1;
		#150;
	endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/*
 Self-checking bench of the frame slave against a reference model.
 Assumes the package, the slave and the host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lss_pkg::*;
	localparam int WDOG = 200;
	localparam logic [7:0] ID_H = 8'h5a; // Arbitrary value
	localparam logic [7:0] ID_V = 8'h01; // Arbitrary value
	localparam logic [7:0] ID_P1 = 8'h11; // Arbitrary value
	localparam logic [7:0] ID_P2 = 8'h22; // Arbitrary value
	logic clk_sys_in, rst_n_in, sclk, select_n, sdi, sdo, sdo_oe_n;
	lss_fault_type fault_in;
	logic case_warn, uv, slow, normal, b, oe_n;
	logic [7:0] status;
	logic [3:0] ch_en;
	logic [15:0] rx;
	logic [7:0] m_reg [0:63];
	logic [7:0] pend;
	logic m_normal, m_chip, m_com;
	int fails = 0;
	int compares = 0;
	integer seed = 32'h4677;
	logic [31:0] r;

	initial begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end

	lss_spi_slave #(.WDOG_CYCLES(WDOG), .ID_HEADER(ID_H), .ID_VERSION(ID_V),
		.ID_PRODUCT_1(ID_P1), .ID_PRODUCT_2(ID_P2)) dut (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .sclk_in(sclk),
		.select_n_in(select_n), .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_n_out(sdo_oe_n),
		.fault_in(fault_in), .case_warn_in(case_warn), .undervoltage_in(uv),
		.pwm_clk_slow_in(slow), .frame_global_status_out(status),
		.normal_mode_out(normal), .channel_enable_out(ch_en));

	lss_host_model host (.sclk_out(sclk), .select_n_out(select_n), .sdi_out(sdi),
		.sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n));

	// ------------------------------------------------------------
	// Reference model and checks
	// ------------------------------------------------------------
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %0t got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] exp_status();
		logic [7:0] s;
		s[6] = m_com;
		s[5] = !(m_chip || m_com);
		s[4] = |(m_reg['h30] | m_reg['h33] | m_reg['h34]);
		s[3] = case_warn;
		s[2] = |m_reg['h31];
		s[1] = |m_reg['h32];
		s[0] = !m_normal;
		s[7] = m_com | m_chip | s[4] | s[2] | s[1] | s[0] | uv | slow;
		return s;
	endfunction

	function automatic logic [7:0] rd(input logic [1:0] op, input logic [5:0] a);
		if (op == LSS_OP_INFO)
			return (a == 6'h3e) ? 8'h01 : (a == 6'h00) ? ID_H : (a == 6'h01) ? ID_V :
				(a == 6'h02) ? ID_P1 : (a == 6'h03) ? ID_P2 : 8'h00;
		return m_reg[a];
	endfunction

	task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, input int n, input bit bad);
		logic [7:0] st;
		logic [7:0] dat;
		st = exp_status();
		dat = rd(cmd[7:6], cmd[5:0]);
		host.frame({cmd, d}, n, bad, rx);
		repeat (4) @(posedge clk_sys_in);
		m_reg['h30] = m_reg['h30] | pend;
		pend = 8'h00;
		if (n != 16 || bad) begin
			m_com = 1'b1;
		end else begin
			chk(rx[15:8], st);
			if (cmd != 8'hff) chk(rx[7:0], dat);
			m_com = 1'b0;
			m_chip = 1'b0;
			if (cmd == 8'hff) begin
				m_reg = '{default: 8'h00};
				m_chip = 1'b1;
				m_normal = 1'b0;
			end else if (cmd[7:6] == LSS_OP_WRITE && cmd[5:1] == 5'h00) begin
				m_normal = m_normal || (!cmd[0] && m_reg[0][4] && d[0]);
				m_reg[cmd[5:0]] = cmd[0] ? {4'h0, d[3:0]} : d;
			end else if (cmd[7:6] == LSS_OP_READ_CLEAR) begin
				for (int k = 0; k < 5; k++) begin
					if (cmd[5:0] == 6'h3f || cmd[5:0] == 6'h30 + 6'(k)) m_reg['h30 + k] = 8'h00;
				end
			end
		end
		chk(status, exp_status());
		chk({7'h0, normal}, {7'h0, m_normal});
		chk({4'h0, ch_en}, m_reg[1]);
	endtask

	task automatic fault(input int k, input int ch);
		@(posedge clk_sys_in);
		fault_in[(4 - k) * 4 + ch] <= 1'b1;
		@(posedge clk_sys_in);
		fault_in <= '0;
		m_reg['h30 + k][ch] = 1'b1;
		repeat (4) @(posedge clk_sys_in);
	endtask

	task automatic finish_test();
		if (fails == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		rst_n_in = 1'b0;
		fault_in = '0;
		case_warn = 1'b0;
		uv = 1'b0;
		slow = 1'b0;
		pend = 8'h00;
		m_reg = '{default: 8'h00};
		m_normal = 1'b0;
		m_chip = 1'b1;
		m_com = 1'b0;
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_sys_in);
		chk(status, 8'h81);
		host.peek(b, oe_n);
		chk({7'h0, b}, 8'h01);
		chk({6'h0, oe_n, sdo_oe_n}, 8'h01);
		chk(status, exp_status());
		for (int i = 0; i < 5; i++) begin
			xfer({2'b11, (i == 4) ? 6'h3e : 6'(i)}, 8'h00, 16, 0);
		end
		r = $random(seed);
		xfer({2'b00, 6'h01}, {4'h0, r[3:0]}, 16, 0);
		xfer({2'b00, 6'h01}, {4'h0, ~r[3:0]}, 16, 0);
		xfer({2'b01, 6'h01}, r[11:4], 16, 0);
		for (int i = 0; i < 3; i++) begin
			xfer({2'b00, 6'h01}, 8'h05, (i == 0) ? 15 : (i == 1) ? 17 : 16, i == 2);
			xfer({2'b01, 6'h01}, 8'h00, 16, 0);
		end
		host.peek(b, oe_n);
		chk({7'h0, b}, exp_status() >> 7);
		r = $random(seed);
		for (int i = 0; i < 4; i++) begin
			xfer({2'(i), 6'h35 + {3'h0, r[2:0]}}, 8'hff, 16, 0);
		end
		for (int k = 0; k < 5; k++) begin
			fault(k, k % 4);
			xfer({2'b01, 6'h30 + 6'(k)}, 8'h00, 16, 0);
			xfer({2'b10, 6'h30 + 6'(k)}, 8'h00, 16, 0);
		end
		fault(0, 3);
		fault(2, 1);
		xfer({2'b10, 6'h3f}, 8'h00, 16, 0);
		fork
			xfer({2'b01, 6'h30}, 8'h00, 16, 0);
			begin
				repeat (30) @(posedge clk_sys_in);
				fault_in[16] <= 1'b1;
				pend = 8'h01;
				@(posedge clk_sys_in);
				fault_in <= '0;
			end
		join
		for (int i = 0; i < 2; i++) begin
			case_warn <= (i == 0);
			repeat (4) @(posedge clk_sys_in);
			chk(status, exp_status());
		end
		xfer({2'b10, 6'h3f}, 8'h00, 16, 0);
		xfer({2'b00, 6'h00}, 8'h10, 16, 0);
		xfer({2'b00, 6'h00}, 8'h11, 16, 0);
		for (int i = 0; i < 3; i++) begin
			uv <= (i == 0);
			slow <= (i == 1);
			repeat (4) @(posedge clk_sys_in);
			chk(status, exp_status());
		end
		for (int i = 0; i < 3; i++) begin
			repeat (100) @(posedge clk_sys_in);
			xfer({2'b01, 6'h00}, 8'h00, 16, 0);
		end
		repeat (WDOG + 20) @(posedge clk_sys_in);
		m_normal = 1'b0;
		chk(status, exp_status());
		xfer({2'b01, 6'h00}, 8'h00, 16, 0);
		xfer(8'hff, 8'h00, 16, 0);
		xfer({2'b01, 6'h01}, 8'h00, 16, 0);
		chk(8'(host.bad_status), 8'h00);
		finish_test();
	end

	initial begin
		#2_000_000;
		fails++;
		finish_test();
	end
endmodule
`default_nettype wire

/* verilog/lss_map.svh */
/*
 Constants of the serial frame and status slave: addresses, bit positions,
 reset values and timing. Assumes inclusion by its bare name.
*/
`ifndef LSS_MAP_SVH
`define LSS_MAP_SVH

// ------------------------------------------------------------
// Frame layout
// ------------------------------------------------------------
`define LSS_FRAME_BITS 5'h10
`define LSS_CNT_SAT 5'h1f
`define LSS_BYTE_BITS 5'h08
`define LSS_SW_RESET_CMD 8'hff
`define LSS_FRAME_WIDTH_INFO 8'h01

// ------------------------------------------------------------
// Register addresses
// ------------------------------------------------------------
`define LSS_ADDR_CTRL 6'h00
`define LSS_ADDR_OUT_CTRL 6'h01
`define LSS_ADDR_ID_HEADER 6'h00
`define LSS_ADDR_VERSION 6'h01
`define LSS_ADDR_PRODUCT_1 6'h02
`define LSS_ADDR_PRODUCT_2 6'h03
`define LSS_ADDR_STATUS_FIRST 6'h30
`define LSS_ADDR_FRAME_WIDTH 6'h3e
`define LSS_ADDR_GLOBAL_CFG 6'h3f

// ------------------------------------------------------------
// Control and status bits
// ------------------------------------------------------------
`define LSS_CTRL_EN_BIT 0
`define LSS_CTRL_UNLOCK_BIT 4
`define LSS_ST_GLOBAL_ERR 7
`define LSS_ST_COM_ERR 6
`define LSS_ST_NOT_RESET 5
`define LSS_ST_FAULT 4
`define LSS_ST_CASE_WARN 3
`define LSS_ST_ON_OPEN 2
`define LSS_ST_OFF_OPEN 1
`define LSS_ST_FAIL_SAFE 0
`define LSS_STATUS_RESET 8'h81

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define LSS_CLK_KHZ 40000
`define LSS_WDOG_TIME_MS 30

`endif

/* verilog/lss_pkg.sv */
/*
 Types of the serial frame and status slave.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package lss_pkg;

	// ------------------------------------------------------------
	// Operation codes and command byte
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		LSS_OP_WRITE,
		LSS_OP_READ,
		LSS_OP_READ_CLEAR,
		LSS_OP_INFO
	} lss_opcode_type;

	typedef struct packed {
		logic opcode_hi;
		logic opcode_lo;
		logic [5:0] addr;
	} lss_cmd_type;

	// ------------------------------------------------------------
	// Per-channel fault events, one bit per channel
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] overtemp_flag;
		logic [3:0] open_load_on_flag;
		logic [3:0] open_load_off_flag;
		logic [3:0] power_limit_flag;
		logic [3:0] turnoff_overload_flag;
	} lss_fault_type;

endpackage
`default_nettype wire

/* verilog/lss_spi_slave.sv */
/*
 Serial 16-bit frame slave with global status byte, frame-length check,
 select watchdog and register image. Assumes a mode 0 master on the link
 pins and fault sources synchronous to clk_sys_in.
*/
// Operation
// - 16-bit frames, both directions most significant bit first
// - Input bit captured on each rising serial clock edge while selected
// - First output bit at select fall, later bits on falling clock edges
// - Output released while select is high
// - Only frames of exactly sixteen pulses take effect
// - Select not toggled within timeout leaves normal for fail-safe
// - Command byte: two opcode bits on top, six address bits below
// - Second input byte is data, most significant bit first
// - Output is status byte then one data byte
// - Status bit 7 global error, reset 1, set by any fault
// - Bit 7 readable with idle clock, no communication error then
// - Wrong pulse count or bad mode sets bit 6, frame ignored
// - Bit 6 shown next frame, cleared by a valid frame
// - Bit 5 low after reset or error, high after valid frame
// - Bit 4 ORs overtemp, power-limit and overload status registers
// - Bit 3 follows case-temperature warning
// - Bit 2 ORs on-state open-load status register
// - Bit 1 ORs off-state open-load status register
// - Bit 0 high in fail-safe, reset 1
// - Status contents frozen while a frame runs
// - Write frame returns previous register content
// - Unassigned address reads zero with no effect
// - Opcodes: write, read, read-and-clear, device information
`include "lss_map.svh"
`timescale 1ns/1ps
`default_nettype none
module lss_spi_slave #(
	parameter int unsigned WDOG_CYCLES = `LSS_WDOG_TIME_MS * `LSS_CLK_KHZ,
	parameter logic [7:0] ID_HEADER = 8'h5a,
	parameter logic [7:0] ID_VERSION = 8'h01,
	parameter logic [7:0] ID_PRODUCT_1 = 8'h11,
	parameter logic [7:0] ID_PRODUCT_2 = 8'h22
) (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic sclk_in,
	input wire logic select_n_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_n_out,
	input wire lss_pkg::lss_fault_type fault_in,
	input wire logic case_warn_in,
	input wire logic undervoltage_in,
	input wire logic pwm_clk_slow_in,
	output logic [7:0] frame_global_status_out,
	output logic normal_mode_out,
	output logic [3:0] channel_enable_out
);
	import lss_pkg::*;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	function automatic logic addr_writable(input logic [5:0] a);
		addr_writable = (a <= 6'h09) || (a >= 6'h10 && a <= 6'h13) ||
			(a >= 6'h18 && a <= 6'h1b) || (a >= 6'h3e);
	endfunction
	function automatic logic addr_used(input logic [5:0] a);
		addr_used = addr_writable(a) || (a >= 6'h2e && a <= 6'h34);
	endfunction
	function automatic lss_opcode_type opcode_of(input lss_cmd_type c);
		opcode_of = lss_opcode_type'({c.opcode_hi, c.opcode_lo});
	endfunction

	// ------------------------------------------------------------
	// Link domain: frame marker and bus mode check
	// ------------------------------------------------------------
	logic frame_seq;
	logic mode_bad;
	always_ff @(negedge select_n_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_seq <= 1'b0;
			mode_bad <= 1'b0;
		end else begin
			frame_seq <= frame_seq ^ (seq_seen == frame_seq);
			mode_bad <= sclk_in;
		end
	end

	// ------------------------------------------------------------
	// Link domain: input shifter and pulse counter
	// ------------------------------------------------------------
	logic seq_seen;
	logic [4:0] bit_cnt;
	logic [15:0] shift;
	always_ff @(posedge sclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			seq_seen <= 1'b0;
			bit_cnt <= 5'h00;
			shift <= 16'h0000;
		end else if (!select_n_in) begin
			if (seq_seen != frame_seq) begin
				seq_seen <= frame_seq;
				bit_cnt <= 5'h01;
				shift <= {15'h0000, sdi_in};
			end else begin
				if (bit_cnt != `LSS_CNT_SAT) begin
					bit_cnt <= bit_cnt + 5'h01;
				end
				shift <= {shift[14:0], sdi_in};
			end
		end
	end

	// ------------------------------------------------------------
	// Link domain: output data lookup
	// ------------------------------------------------------------
	logic [7:0] regs [64];
	lss_cmd_type rx_cmd;
	logic [7:0] rd_lookup;
	assign rx_cmd = lss_cmd_type'(shift[7:0]);
	always_comb begin
		rd_lookup = 8'h00;
		unique case (opcode_of(rx_cmd))
			LSS_OP_INFO: begin
				unique case (rx_cmd.addr)
					`LSS_ADDR_ID_HEADER: rd_lookup = ID_HEADER;
					`LSS_ADDR_VERSION: rd_lookup = ID_VERSION;
					`LSS_ADDR_PRODUCT_1: rd_lookup = ID_PRODUCT_1;
					`LSS_ADDR_PRODUCT_2: rd_lookup = ID_PRODUCT_2;
					`LSS_ADDR_FRAME_WIDTH: rd_lookup = `LSS_FRAME_WIDTH_INFO;
					default: rd_lookup = 8'h00;
				endcase
			end
			LSS_OP_WRITE, LSS_OP_READ, LSS_OP_READ_CLEAR: begin
				if (addr_used(rx_cmd.addr)) begin
					rd_lookup = regs[rx_cmd.addr];
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Link domain: serial output
	// ------------------------------------------------------------
	logic out_clr;
	logic out_valid;
	logic sdo_bit;
	logic [7:0] rd_byte;
	assign out_clr = select_n_in | ~rst_n_in;
	always_ff @(negedge sclk_in or posedge out_clr) begin
		if (out_clr) begin
			out_valid <= 1'b0;
		end else begin
			out_valid <= 1'b1;
		end
	end

	always_ff @(negedge sclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sdo_bit <= 1'b0;
			rd_byte <= 8'h00;
		end else if (!select_n_in) begin
			if (bit_cnt < `LSS_BYTE_BITS) begin
				sdo_bit <= frame_global_status_out[3'(5'h07 - bit_cnt)];
			end else if (bit_cnt == `LSS_BYTE_BITS) begin
				sdo_bit <= rd_lookup[7];
				rd_byte <= rd_lookup;
			end else if (bit_cnt < `LSS_FRAME_BITS) begin
				sdo_bit <= rd_byte[3'(5'h0f - bit_cnt)];
			end else begin
				sdo_bit <= 1'b0;
			end
		end
	end
	assign sdo_out = out_valid ? sdo_bit : frame_global_status_out[7];
	assign sdo_oe_n_out = select_n_in;

	// ------------------------------------------------------------
	// System domain: select synchroniser and frame end
	// ------------------------------------------------------------
	logic [1:0] sel_sync;
	logic sel_prev;
	logic frame_end;
	logic idle;
	logic zero_pulse;
	logic frame_bad;
	logic frame_ok;
	logic sw_reset;
	lss_cmd_type ev_cmd;
	logic [7:0] ev_data;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sel_sync <= 2'b11;
			sel_prev <= 1'b1;
		end else begin
			sel_sync <= {sel_sync[0], select_n_in};
			sel_prev <= sel_sync[1];
		end
	end

	assign idle = sel_sync[1];
	assign frame_end = sel_sync[1] & ~sel_prev;
	assign zero_pulse = (seq_seen != frame_seq);
	assign frame_bad = (!zero_pulse && bit_cnt != `LSS_FRAME_BITS) || mode_bad;
	assign frame_ok = !zero_pulse && !frame_bad;
	assign ev_cmd = lss_cmd_type'(shift[15:8]);
	assign ev_data = shift[7:0];
	assign sw_reset = frame_end && frame_ok && (shift[15:8] == `LSS_SW_RESET_CMD);

	// ------------------------------------------------------------
	// System domain: fault events held back during a frame
	// ------------------------------------------------------------
	logic [19:0] pend;
	logic [19:0] fault_now;
	assign fault_now = pend | fault_in;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend <= 20'h0_0000;
		end else if (idle) begin
			pend <= 20'h0_0000;
		end else begin
			pend <= fault_now;
		end
	end

	// ------------------------------------------------------------
	// System domain: register image
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < 64; i++) begin
				regs[i] <= 8'h00;
			end
		end else if (sw_reset) begin
			for (int i = 0; i < 64; i++) begin
				regs[i] <= 8'h00;
			end
		end else begin
			if (frame_end && frame_ok && opcode_of(ev_cmd) == LSS_OP_WRITE &&
				addr_writable(ev_cmd.addr)) begin
				regs[ev_cmd.addr] <= ev_data;
			end
			for (int i = 0; i < 5; i++) begin
				if (idle) begin
					regs[6'(int'(`LSS_ADDR_STATUS_FIRST) + i)] <=
						(regs[6'(int'(`LSS_ADDR_STATUS_FIRST) + i)] &
						~((frame_end && frame_ok && opcode_of(ev_cmd) == LSS_OP_READ_CLEAR &&
						(ev_cmd.addr == 6'(int'(`LSS_ADDR_STATUS_FIRST) + i) ||
						ev_cmd.addr == `LSS_ADDR_GLOBAL_CFG)) ? 8'h0f : 8'h00)) |
						{4'h0, fault_now[19 - 4 * i -: 4]};
				end
			end
		end
	end

	// ------------------------------------------------------------
	// System domain: error, reset and mode flags
	// ------------------------------------------------------------
	logic com_err;
	logic chip_reset;
	logic [31:0] wd_cnt;
	logic wd_timeout;

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			com_err <= 1'b0;
		end else if (frame_end && frame_bad) begin
			com_err <= 1'b1;
		end else if (frame_end && frame_ok) begin
			com_err <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			chip_reset <= 1'b1;
		end else if (sw_reset) begin
			chip_reset <= 1'b1;
		end else if (frame_end && frame_ok) begin
			chip_reset <= 1'b0;
		end
	end

	assign wd_timeout = normal_mode_out && (sel_sync[1] == sel_prev) &&
		(wd_cnt == WDOG_CYCLES - 1);

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wd_cnt <= 32'h0000_0000;
		end else if (!normal_mode_out || sel_sync[1] != sel_prev) begin
			wd_cnt <= 32'h0000_0000;
		end else if (!wd_timeout) begin
			wd_cnt <= wd_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			normal_mode_out <= 1'b0;
		end else if (wd_timeout || sw_reset) begin
			normal_mode_out <= 1'b0;
		end else if (frame_end && frame_ok && opcode_of(ev_cmd) == LSS_OP_WRITE &&
			ev_cmd.addr == `LSS_ADDR_CTRL && ev_data[`LSS_CTRL_EN_BIT] &&
			regs[`LSS_ADDR_CTRL][`LSS_CTRL_UNLOCK_BIT]) begin
			normal_mode_out <= 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			channel_enable_out <= 4'h0;
		end else begin
			channel_enable_out <= regs[`LSS_ADDR_OUT_CTRL][3:0];
		end
	end

	// ------------------------------------------------------------
	// System domain: global status byte
	// ------------------------------------------------------------
	logic [7:0] next_status;
	logic any_channel_fault;

	always_comb begin
		any_channel_fault = 1'b0;
		for (int i = 0; i < 5; i++) begin
			any_channel_fault = any_channel_fault |
				(|regs[6'(int'(`LSS_ADDR_STATUS_FIRST) + i)]);
		end
		next_status = 8'h00;
		next_status[`LSS_ST_GLOBAL_ERR] = any_channel_fault | !normal_mode_out | com_err |
			chip_reset | undervoltage_in | pwm_clk_slow_in;
		next_status[`LSS_ST_COM_ERR] = com_err;
		next_status[`LSS_ST_NOT_RESET] = ~(chip_reset | com_err);
		next_status[`LSS_ST_FAULT] = |{regs[6'h30], regs[6'h33], regs[6'h34]};
		next_status[`LSS_ST_CASE_WARN] = case_warn_in;
		next_status[`LSS_ST_ON_OPEN] = |regs[6'h31];
		next_status[`LSS_ST_OFF_OPEN] = |regs[6'h32];
		next_status[`LSS_ST_FAIL_SAFE] = !normal_mode_out;
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			frame_global_status_out <= `LSS_STATUS_RESET;
		end else if (idle) begin
			frame_global_status_out <= next_status;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	bad_frame_flag_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		frame_end && frame_bad |=> com_err)
		else $error("bad frame did not raise error");
	good_frame_clear_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		frame_end && frame_ok && !sw_reset |=> !com_err && !chip_reset)
		else $error("valid frame did not clear flags");
	idle_read_quiet_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		frame_end && zero_pulse && !mode_bad |=> $stable(com_err))
		else $error("idle read changed error flag");
	status_frozen_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!sel_sync[1] && !$past(sel_sync[1]) |-> $stable(frame_global_status_out))
		else $error("status moved during frame");
	error_status_shown_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		frame_end && frame_bad ##1 sel_sync[1] |=>
		frame_global_status_out[6] && !frame_global_status_out[5] &&
		frame_global_status_out[7])
		else $error("error not in status byte");
	fail_safe_bit_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		!normal_mode_out && sel_sync[1] |=> frame_global_status_out[0])
		else $error("fail-safe bit not shown");
	watchdog_trip_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		normal_mode_out && wd_cnt == WDOG_CYCLES - 1 && sel_sync[1] == sel_prev
		|=> !normal_mode_out)
		else $error("watchdog did not leave normal mode");
	write_store_a: assert property (
		@(posedge clk_sys_in) disable iff (!rst_n_in)
		frame_end && frame_ok && !sw_reset && opcode_of(ev_cmd) == LSS_OP_WRITE &&
		addr_writable(ev_cmd.addr) |=> regs[$past(shift[13:8])] == $past(shift[7:0]))
		else $error("write data not stored");
	sdo_first_bit_a: assert property (
		@(posedge sclk_in) disable iff (!rst_n_in)
		!select_n_in && !mode_bad && (seq_seen != frame_seq) |->
		sdo_out == frame_global_status_out[7])
		else $error("first output bit not status bit 7");
endmodule
`default_nettype wire
